// File: design/ssac_pkg.sv
// Constants and types for the supercap safety action configuration bank
package ssac_pkg;
   // Safety flag bit positions, shared by both masks and the flags register
   localparam int FLG_WEAK_CAP = 15;
   localparam int FLG_HEALTH_FAIL = 14;
   localparam int FLG_HEALTH_WARN = 13;
   localparam int FLG_HEALTH_LOW = 12;
   localparam int FLG_RSVD_HI = 11;
   localparam int FLG_CHG_OVERTEMP = 10;
   localparam int FLG_CAP_IMBALANCE = 9;
   localparam int FLG_CAP_OVERVOLT = 8;
   localparam int FLG_NVM_ERROR = 7;
   localparam int FLG_RSVD_LO = 6;
   localparam int FLG_FE_COMM_FAIL = 5;
   localparam int FLG_FE_WATCHDOG = 4;
   localparam int FLG_CHG_OVERCUR = 3;
   localparam int FLG_DSG_OVERCUR = 2;
   localparam int FLG_CHG_SHORT = 1;
   localparam int FLG_DSG_SHORT = 0;
   // Front-end control byte fields
   localparam int FE_SHORT_DELAY_DOUBLE_BIT = 5;
   localparam int FE_LOW_SENSE_RANGE_BIT = 4;
   // Register byte addresses on APB
   localparam logic [7:0] ADDR_TRIP_MASK = 8'h00;
   localparam logic [7:0] ADDR_ALERT_MASK = 8'h04;
   localparam logic [7:0] ADDR_FE_CTL = 8'h08;
   localparam logic [7:0] ADDR_MARGIN = 8'h0c;
   localparam logic [7:0] ADDR_V_NOM = 8'h10;
   localparam logic [7:0] ADDR_V_A = 8'h14;
   localparam logic [7:0] ADDR_V_B = 8'h18;
   localparam logic [7:0] ADDR_V_MAX = 8'h1c;
   localparam logic [7:0] ADDR_MAX_DSG = 8'h20;
   localparam logic [7:0] ADDR_MIN_V = 8'h24;
   localparam logic [7:0] ADDR_INTERVAL = 8'h28;
   localparam logic [7:0] ADDR_FLAGS = 8'h2c;
   localparam logic [7:0] ADDR_STATUS = 8'h30;
   // Reset values
   localparam logic [15:0] RST_TRIP_MASK = 16'h0000;
   localparam logic [15:0] RST_ALERT_MASK = 16'h0000;
   localparam logic [7:0] RST_FE_CTL = 8'h00;
   localparam logic [7:0] RST_MARGIN = 8'h0a;
   localparam logic [15:0] RST_V_NOM = 16'h28a0;
   localparam logic [15:0] RST_V_A = 16'h2b75;
   localparam logic [15:0] RST_V_B = 16'h2e63;
   localparam logic [16:0] RST_V_MAX = 17'h1e848;
   localparam logic [15:0] RST_MAX_DSG = 16'h000a;
   localparam logic [15:0] RST_MIN_V = 16'h0fa0;
   localparam logic [7:0] RST_INTERVAL = 8'h02;
   // Value limits
   localparam logic [15:0] LIM_V_CHG = 16'h61a8;
   localparam logic [15:0] LIM_MAX_DSG = 16'h7fff;
   localparam logic [15:0] LIM_MIN_V = 16'h2710;
   localparam logic [7:0] LIM_MARGIN = 8'h64;
   localparam logic [7:0] INTERVAL_TEST_CODE = 8'hfa;
   // Short-circuit threshold ladders, millivolts
   localparam logic [8:0] THR_BASE_MV = 9'h064;
   localparam logic [8:0] THR_STEP_MV = 9'h032;
   // Time figures and cycle counts
   localparam int CLK_HZ = 25000000;
   localparam int TICK_S = 1;
   localparam int SEC_CYCLES = CLK_HZ * TICK_S;
   localparam int WEEK_S = 604800;
   localparam int TEST_INTERVAL_MIN = 10;
   localparam logic [27:0] TEST_INTERVAL_S = 28'(TEST_INTERVAL_MIN * 60);
   localparam logic [27:0] WEEK_S_W = 28'(WEEK_S);
   typedef enum logic [0:0] {LRN_WAIT, LRN_RUN} ssac_learn_t;
endpackage

// File: design/ssac_config.sv
// Safety action masks, front-end control, charge targets and learning scheduler
//
// Contract
// - Trip-masked set flag switches charge FET off
// - Bits 15..8: weak, fail, warn, low, rsvd, ot, imb, ov
// - Bits 7..0: nvm, rsvd, comm, wdog, occ, ocd, scc, scd
// - Alert mask selects flags reported on alert pin
// - Delay-double bit doubles short-circuit delay
// - Low-sense bit halves short-circuit thresholds
// - Both selects low: nominal voltage, limit 25000
// - Select lo only: level A, default 11125
// - Select hi only: level B, default 11875
// - Both selects high: maximum level target
// - Learning bounded by max discharge seconds
// - Margin percent 0..100, default 10
// - Minimum voltage 0..10000, default 4000
// - Learning cycles start periodically
// - Interval in weeks; code 250 means ten minutes
// - Doubling also applies to charge short delay
// - Low-sense codes step 25 mV from 50 mV
`timescale 1ns/1ps
module ssac_config #(
   parameter int SEC_CYCLES_P = ssac_pkg::SEC_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] safety_flags,
   input wire logic charge_level_sel_hi,
   input wire logic charge_level_sel_lo,
   input wire logic [3:0] short_delay_code,
   input wire logic [2:0] short_threshold_sel,
   input wire logic learn_done,
   output logic chg_fet_en,
   output logic alert_out,
   output logic [16:0] charge_target_mv,
   output logic [4:0] short_delay_steps,
   output logic [8:0] short_threshold_mv,
   output logic learn_start,
   output logic learn_active,
   output logic [7:0] learn_margin_pct,
   output logic [15:0] learn_min_mv
);
   import ssac_pkg::*;

   typedef struct packed {
      logic [15:0] trip;
      logic [15:0] alert_m;
      logic dbl;
      logic low_sense_range;
      logic [7:0] margin;
      logic [15:0] v_nom;
      logic [15:0] v_a;
      logic [15:0] v_b;
      logic [16:0] v_max;
      logic [15:0] max_dsg;
      logic [15:0] min_v;
      logic [7:0] interval;
      logic [1:0] sel_m;
      logic [1:0] sel;
      logic ack;
      logic [31:0] rdata;
      logic fet;
      logic alert;
      logic [16:0] target;
      logic [4:0] delay;
      logic [8:0] thr;
      logic [24:0] tick_cnt;
      logic [27:0] wait_s;
      logic [15:0] run_s;
      ssac_learn_t lrn;
      logic start;
      logic timeout;
   } ssac_state_t;

   ssac_state_t st_r;
   ssac_state_t st_nxt;
   logic wr_acc;
   logic hit;
   logic sec_tick;
   logic [27:0] interval_s;
   logic [31:0] rd_mux;

   function automatic logic [15:0] sat16(input logic [15:0] v, input logic [15:0] lim);
      sat16 = (v > lim) ? lim : v;
   endfunction

   always_comb begin
      case (paddr)
         ADDR_TRIP_MASK, ADDR_ALERT_MASK, ADDR_FE_CTL, ADDR_MARGIN, ADDR_V_NOM,
         ADDR_V_A, ADDR_V_B, ADDR_V_MAX, ADDR_MAX_DSG, ADDR_MIN_V, ADDR_INTERVAL,
         ADDR_FLAGS, ADDR_STATUS: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   // No wait state, yet read data still comes straight from a flip-flop loaded in the setup phase
   assign pready = psel & penable & st_r.ack;
   assign pslverr = pready & ~hit;
   assign wr_acc = pready & pwrite & hit;
   assign prdata = st_r.rdata;
   assign sec_tick = (st_r.tick_cnt == 25'(SEC_CYCLES_P - 1));
   // Code 250 is a short test interval, anything else counts whole weeks
   assign interval_s = (st_r.interval == INTERVAL_TEST_CODE) ? TEST_INTERVAL_S :
      28'(st_r.interval * WEEK_S_W);

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         ADDR_TRIP_MASK: rd_mux = {16'h0000, st_r.trip};
         ADDR_ALERT_MASK: rd_mux = {16'h0000, st_r.alert_m};
         ADDR_FE_CTL: rd_mux = {26'h0, st_r.dbl, st_r.low_sense_range, 4'h0};
         ADDR_MARGIN: rd_mux = {24'h0, st_r.margin};
         ADDR_V_NOM: rd_mux = {16'h0000, st_r.v_nom};
         ADDR_V_A: rd_mux = {16'h0000, st_r.v_a};
         ADDR_V_B: rd_mux = {16'h0000, st_r.v_b};
         ADDR_V_MAX: rd_mux = {15'h0, st_r.v_max};
         ADDR_MAX_DSG: rd_mux = {16'h0000, st_r.max_dsg};
         ADDR_MIN_V: rd_mux = {16'h0000, st_r.min_v};
         ADDR_INTERVAL: rd_mux = {24'h0, st_r.interval};
         ADDR_FLAGS: rd_mux = {16'h0000, safety_flags};
         ADDR_STATUS: rd_mux = {26'h0, st_r.timeout, st_r.lrn == LRN_RUN, st_r.sel,
            st_r.alert, st_r.fet};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = psel & ~penable;
      if (psel && !penable) begin
         st_nxt.rdata = pwrite ? 32'h0000_0000 : rd_mux;
      end
      if (wr_acc) begin
         case (paddr)
            ADDR_TRIP_MASK: st_nxt.trip = pwdata[15:0];
            ADDR_ALERT_MASK: st_nxt.alert_m = pwdata[15:0];
            ADDR_FE_CTL: begin
               // Reserved bits are not stored, so they always read zero
               st_nxt.dbl = pwdata[FE_SHORT_DELAY_DOUBLE_BIT];
               st_nxt.low_sense_range = pwdata[FE_LOW_SENSE_RANGE_BIT];
            end
            ADDR_MARGIN: st_nxt.margin = (pwdata[7:0] > LIM_MARGIN) ? LIM_MARGIN
               : pwdata[7:0];
            ADDR_V_NOM: st_nxt.v_nom = sat16(pwdata[15:0], LIM_V_CHG);
            ADDR_V_A: st_nxt.v_a = sat16(pwdata[15:0], LIM_V_CHG);
            ADDR_V_B: st_nxt.v_b = sat16(pwdata[15:0], LIM_V_CHG);
            ADDR_V_MAX: st_nxt.v_max = {1'b0, sat16(pwdata[15:0], LIM_V_CHG)};
            ADDR_MAX_DSG: st_nxt.max_dsg = sat16(pwdata[15:0], LIM_MAX_DSG);
            ADDR_MIN_V: st_nxt.min_v = sat16(pwdata[15:0], LIM_MIN_V);
            ADDR_INTERVAL: st_nxt.interval = pwdata[7:0];
            default: begin
            end
         endcase
      end
      // Level selects are pins: two flops before use
      st_nxt.sel_m = {charge_level_sel_hi, charge_level_sel_lo};
      st_nxt.sel = st_r.sel_m;
      // Flags come from same-clock logic, so no synchroniser
      st_nxt.fet = ~|(safety_flags & st_r.trip);
      st_nxt.alert = |(safety_flags & st_r.alert_m);
      case (st_r.sel)
         2'b00: st_nxt.target = {1'b0, st_r.v_nom};
         2'b01: st_nxt.target = {1'b0, st_r.v_a};
         2'b10: st_nxt.target = {1'b0, st_r.v_b};
         default: st_nxt.target = st_r.v_max;
      endcase
      st_nxt.delay = st_r.dbl ? {short_delay_code, 1'b0} : {1'b0, short_delay_code};
      // Halving the base ladder lands on 50 mV + 25 mV steps
      st_nxt.thr = 9'(THR_BASE_MV + 9'(short_threshold_sel) * THR_STEP_MV);
      if (st_r.low_sense_range) begin
         st_nxt.thr = {1'b0, st_nxt.thr[8:1]};
      end
      st_nxt.tick_cnt = sec_tick ? 25'h0 : 25'(st_r.tick_cnt + 25'h1);
      st_nxt.start = 1'b0;
      // Write-one clears the timeout flag; a new timeout below wins
      if (wr_acc && paddr == ADDR_STATUS && pwdata[5]) begin
         st_nxt.timeout = 1'b0;
      end
      case (st_r.lrn)
         LRN_WAIT: begin
            // Interval zero disables automatic learning
            if (interval_s != 28'h0 && st_r.wait_s >= interval_s) begin
               st_nxt.lrn = LRN_RUN;
               st_nxt.start = 1'b1;
               st_nxt.wait_s = 28'h0;
               st_nxt.run_s = 16'h0;
            end else if (sec_tick) begin
               st_nxt.wait_s = 28'(st_r.wait_s + 28'h1);
            end
         end
         LRN_RUN: begin
            if (learn_done) begin
               st_nxt.lrn = LRN_WAIT;
            end else if (st_r.run_s >= st_r.max_dsg) begin
               st_nxt.lrn = LRN_WAIT;
               st_nxt.timeout = 1'b1;
            end else if (sec_tick) begin
               st_nxt.run_s = 16'(st_r.run_s + 16'h1);
            end
         end
         default: st_nxt.lrn = LRN_WAIT;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '{trip: RST_TRIP_MASK, alert_m: RST_ALERT_MASK,
            dbl: RST_FE_CTL[FE_SHORT_DELAY_DOUBLE_BIT], low_sense_range: RST_FE_CTL[FE_LOW_SENSE_RANGE_BIT],
            margin: RST_MARGIN, v_nom: RST_V_NOM, v_a: RST_V_A, v_b: RST_V_B, v_max: RST_V_MAX,
            max_dsg: RST_MAX_DSG, min_v: RST_MIN_V, interval: RST_INTERVAL, sel_m: 2'b00,
            sel: 2'b00, ack: 1'b0, rdata: 32'h0, fet: 1'b1, alert: 1'b0, target: 17'h0,
            delay: 5'h0, thr: 9'h0, tick_cnt: 25'h0, wait_s: 28'h0, run_s: 16'h0,
            lrn: LRN_WAIT, start: 1'b0, timeout: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign chg_fet_en = st_r.fet;
   assign alert_out = st_r.alert;
   assign charge_target_mv = st_r.target;
   assign short_delay_steps = st_r.delay;
   assign short_threshold_mv = st_r.thr;
   assign learn_start = st_r.start;
   assign learn_active = (st_r.lrn == LRN_RUN);
   assign learn_margin_pct = st_r.margin;
   assign learn_min_mv = st_r.min_v;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_tripped;
      |(safety_flags & st_r.trip);
   endsequence
   sequence s_clear;
      !(|(safety_flags & st_r.trip));
   endsequence

   a_fet_trip_off: assert property (s_tripped |=> !chg_fet_en)
      else $error("charge FET stayed on with tripped flag");
   a_fet_reenable: assert property (s_tripped ##1 s_clear |=> chg_fet_en)
      else $error("charge FET not re-enabled after flags cleared");
   a_alert_or: assert property (alert_out == $past(|(safety_flags & st_r.alert_m)))
      else $error("alert output does not match masked flags");
   // Skip the release edge: state has not moved yet, target still reads zero
   a_level_nom: assert property ($past(presetn) && st_r.sel == 2'b00
      |=> charge_target_mv == {1'b0, $past(st_r.v_nom)})
      else $error("nominal target not selected");
   a_level_a: assert property ($past(presetn) && st_r.sel == 2'b01
      |=> charge_target_mv == {1'b0, $past(st_r.v_a)})
      else $error("level A target not selected");
   a_level_b: assert property ($past(presetn) && st_r.sel == 2'b10
      |=> charge_target_mv == {1'b0, $past(st_r.v_b)})
      else $error("level B target not selected");
   a_level_max: assert property ($past(presetn) && st_r.sel == 2'b11
      |=> charge_target_mv == $past(st_r.v_max))
      else $error("maximum target not selected");
   a_delay_double: assert property (st_r.dbl |=> short_delay_steps ==
      {$past(short_delay_code), 1'b0})
      else $error("short delay not doubled");
   a_thr_low_sense: assert property (st_r.low_sense_range && $stable(st_r.low_sense_range)
      |=> short_threshold_mv == 9'(9'd50 + 9'd25 * 9'($past(short_threshold_sel))))
      else $error("low-sense threshold wrong");
   a_margin_range: assert property (learn_margin_pct <= LIM_MARGIN)
      else $error("margin above limit");
   a_min_v_range: assert property (learn_min_mv <= LIM_MIN_V)
      else $error("minimum voltage above limit");
   a_learn_bound: assert property (learn_active && !learn_done
      && st_r.run_s >= st_r.max_dsg |=> !learn_active && st_r.timeout)
      else $error("learning not ended at max discharge time");
   // Sticky until software clears it, so a missed poll loses nothing
   a_timeout_hold: assert property (st_r.timeout && !(wr_acc && paddr == ADDR_STATUS)
      |=> st_r.timeout)
      else $error("timeout flag lost without a clear");
   a_learn_start: assert property (learn_start |-> learn_active && $past(!learn_active))
      else $error("learning start without entering run");
   a_start_pulse: assert property (learn_start |=> !learn_start)
      else $error("learning start longer than one cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held past one access cycle");
endmodule // ssac_config

// File: verification/ssac_learn_model.sv
// Far-side learning engine model that ends each learning run unless done_delay is zero
`timescale 1ns/1ps
module ssac_learn_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic learn_active,
   input wire logic [7:0] done_delay,
   output logic learn_done
);
   logic [7:0] cnt_r;
   // Delay zero never answers, so the run must end by its own time limit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 8'h00;
         learn_done <= 1'b0;
      end else begin
         cnt_r <= learn_active ? cnt_r + 8'h01 : 8'h00;
         learn_done <= learn_active && (done_delay != 8'h00) && (cnt_r == done_delay);
      end
   end
endmodule // ssac_learn_model

// File: verification/tb_ssac_config.sv
// Self-checking bench for the safety action configuration bank
`timescale 1ns/1ps
module tb_ssac_config;
   import ssac_pkg::*;
   // Short second keeps the learning interval within a short run
   localparam int SECP = 4;
   localparam logic [31:0] RST_EXP [11] = '{32'h0, 32'h0, 32'h0, 32'ha, 32'h28a0, 32'h2b75,
      32'h2e63, 32'h1e848, 32'ha, 32'hfa0, 32'h2};
   localparam logic [31:0] TGT [4] = '{32'd10400, 32'd11125, 32'd11875, 32'd125000};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic charge_level_sel_hi, charge_level_sel_lo, learn_done, chg_fet_en, alert_out;
   logic learn_start, learn_active;
   logic [7:0] paddr, learn_margin_pct, done_delay;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] safety_flags, learn_min_mv;
   logic [16:0] charge_target_mv;
   logic [4:0] short_delay_steps;
   logic [8:0] short_threshold_mv;
   logic [3:0] short_delay_code;
   logic [2:0] short_threshold_sel;
   int mismatches, comparisons, n;

   ssac_config #(.SEC_CYCLES_P(SECP)) i_ssac_config (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .safety_flags,
      .charge_level_sel_hi, .charge_level_sel_lo, .short_delay_code, .short_threshold_sel,
      .learn_done, .chg_fet_en, .alert_out, .charge_target_mv, .short_delay_steps,
      .short_threshold_mv, .learn_start, .learn_active, .learn_margin_pct, .learn_min_mv);
   ssac_learn_model i_ssac_learn_model (.pclk, .presetn, .learn_active, .done_delay,
      .learn_done);

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   task automatic tally_and_finish();
      if (mismatches == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; held until pready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      // Ready is looked at mid-cycle, away from the edge that moves it
      do begin
         @(negedge pclk);
         k++;
         err = pslverr;
      end while (pready !== 1'b1 && k < 16);
      if (pready !== 1'b1) begin
         mismatches++;
         tally_and_finish();
      end
      @(posedge pclk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wait_start(input int lim);
      n = 0;
      // One-cycle pulse: sample it where it is settled
      do begin
         @(negedge pclk);
         n++;
      end while (learn_start !== 1'b1 && n < lim);
      if (learn_start !== 1'b1) begin
         mismatches++;
         tally_and_finish();
      end
   endtask

   initial begin
      {presetn, psel, penable, pwrite, charge_level_sel_hi, charge_level_sel_lo} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      safety_flags = 16'h0;
      short_delay_code = 4'hf;
      short_threshold_sel = 3'h7;
      done_delay = 8'h02;
      mismatches = 0;
      comparisons = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check({24'h0, learn_margin_pct}, 32'd10);
      check({16'h0, learn_min_mv}, 32'd4000);
      for (int i = 0; i < 11; i++) begin
         xfer(1'b0, 8'(i * 4), 32'h0);
         check(rd, RST_EXP[i]);
      end
      xfer(1'b0, 8'h3c, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      // Walking bit: trip and alert masks disjoint, so each output must follow its own mask
      for (int k = 0; k < 16; k++) begin
         xfer(1'b1, ADDR_TRIP_MASK, 32'h1 << k);
         xfer(1'b1, ADDR_ALERT_MASK, ~(32'h1 << k) & 32'hffff);
         safety_flags <= 16'h1 << k;
         repeat (2) @(posedge pclk);
         check({31'h0, chg_fet_en}, 32'h0);
         check({31'h0, alert_out}, 32'h0);
         xfer(1'b0, ADDR_FLAGS, 32'h0);
         check(rd, 32'h1 << k);
         safety_flags <= ~(16'h1 << k);
         repeat (2) @(posedge pclk);
         check({31'h0, chg_fet_en}, 32'h1);
         check({31'h0, alert_out}, 32'h1);
      end
      safety_flags <= 16'h0;
      repeat (2) @(posedge pclk);
      check({31'h0, alert_out}, 32'h0);
      for (int m = 0; m < 4; m++) begin
         xfer(1'b1, ADDR_FE_CTL, 32'(m) << 4);
         repeat (2) @(posedge pclk);
         check({27'h0, short_delay_steps}, m[1] ? 32'd30 : 32'd15);
         check({23'h0, short_threshold_mv}, m[0] ? 32'd225 : 32'd450);
      end
      xfer(1'b0, ADDR_FE_CTL, 32'h0);
      check(rd, 32'h30);
      // Selects pass a two-flop synchroniser first
      for (int m = 0; m < 4; m++) begin
         {charge_level_sel_hi, charge_level_sel_lo} <= 2'(m);
         repeat (5) @(posedge pclk);
         check({15'h0, charge_target_mv}, TGT[m]);
      end
      {charge_level_sel_hi, charge_level_sel_lo} <= 2'b00;
      xfer(1'b1, ADDR_V_NOM, 32'd30000);
      repeat (4) @(posedge pclk);
      check({15'h0, charge_target_mv}, 32'd25000);
      xfer(1'b1, ADDR_MARGIN, 32'd150);
      xfer(1'b1, ADDR_MIN_V, 32'd12000);
      check({24'h0, learn_margin_pct}, 32'd100);
      check({16'h0, learn_min_mv}, 32'd10000);
      xfer(1'b1, ADDR_MAX_DSG, 32'd40000);
      xfer(1'b0, ADDR_MAX_DSG, 32'h0);
      check(rd, 32'h7fff);
      xfer(1'b1, ADDR_MAX_DSG, 32'd10);
      xfer(1'b1, ADDR_INTERVAL, 32'd250);
      wait_start(3000);
      check({31'h0, learn_active}, 32'h1);
      @(posedge pclk);
      wait_start(3000);
      // 600 s of four-cycle seconds, plus the short first run and tick phase
      check(32'(n >= 2400 && n <= 2408), 32'h1);
      @(posedge pclk);
      // Far side goes silent: the run must end on the discharge time limit
      done_delay <= 8'h00;
      xfer(1'b1, ADDR_MAX_DSG, 32'd3);
      wait_start(3000);
      n = 0;
      while (learn_active === 1'b1 && n < 40) begin
         @(negedge pclk);
         n++;
      end
      check(32'(n >= 10 && n <= 17), 32'h1);
      @(posedge pclk);
      xfer(1'b0, ADDR_STATUS, 32'h0);
      check(rd & 32'h20, 32'h20);
      xfer(1'b1, ADDR_STATUS, 32'h20);
      xfer(1'b0, ADDR_STATUS, 32'h0);
      check(rd & 32'h20, 32'h0);
      tally_and_finish();
   end
endmodule // tb_ssac_config
